// ---- hwmon_pkg.sv ----
package hwmon_pkg;
	localparam logic [7:0] ADDR_ZONE1_ABS = 8'h6a;
	localparam logic [7:0] ADDR_ZONE2_ABS = 8'h6b;
	localparam logic [7:0] ADDR_ZONE3_ABS = 8'h6c;
	localparam logic [7:0] ADDR_PARITY_TEST = 8'h6f;
	localparam logic [7:0] ADDR_SPECIAL = 8'h7c;
	localparam logic [7:0] ABS_LIMIT_RST = 8'h64;
	localparam logic [7:0] ABS_LIMIT_OFF = 8'h80;
	localparam logic [7:0] ABS_LIMIT_MAX = 8'h7f;
	localparam logic [7:0] PARITY_TEST_RST = 8'h00;
	localparam logic [7:0] SPECIAL_RST = 8'h40;
	localparam logic [7:0] FULL_DUTY = 8'hff;
	localparam int BIT_POWER_SAVE = 0;
	localparam int BIT_MON_CYCLE = 1;
	localparam int BIT_IRQ_EN = 2;
	localparam int BIT_AVG_LO = 5;
	localparam int NUM_ZONES = 3;
	localparam int NUM_FANS = 3;
	localparam int NUM_SPEED_IN = 4;
	localparam logic [7:0] AVG_128 = 8'h80;
	localparam logic [7:0] AVG_32 = 8'h20;
	localparam logic [7:0] AVG_16 = 8'h10;
	localparam logic [7:0] AVG_8 = 8'h08;
	localparam logic [7:0] AVG_1 = 8'h01;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] remote_count;
		logic [7:0] local_count;
	} avg_count_t;
endpackage

// ---- avg_decode.sv ----
`timescale 1ns/1ns
module avg_decode
	import hwmon_pkg::*;
(
	input wire logic [2:0] sel,
	output avg_count_t counts
);
	// top bit wins, then middle bit, then low bit
	wire logic hi_set = sel[2];
	wire logic mid_set = sel[1];
	assign counts.remote_count = hi_set ? AVG_32 : mid_set ? AVG_16 : sel[0] ? AVG_16 : AVG_128;
	assign counts.local_count = hi_set ? AVG_32 : mid_set ? AVG_16 : sel[0] ? AVG_1 : AVG_8;
endmodule

// ---- abs_override.sv ----
`timescale 1ns/1ns
module abs_override
	import hwmon_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reading,
	input wire logic reading_upd,
	input wire logic [7:0] limit,
	output logic over
);
	wire logic disabled = (limit == ABS_LIMIT_OFF);
	wire logic above = $signed(reading) > $signed(limit);
	logic over_r;
	always_ff @(posedge clk)
	begin
		if (rst)
			over_r <= 1'b0;
		else if (disabled)
			over_r <= 1'b0;
		else if (reading_upd)
			over_r <= above;
	end
	assign over = over_r;
endmodule

// ---- hwmon_regs.sv ----
`timescale 1ns/1ns
module hwmon_regs
	import hwmon_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input hwmon_pkg::reg_req_t REG_REQ,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic LOCK,
	input wire logic [2:0] AUTO_MODE,
	input wire logic [2:0] FAN_DISABLE,
	input wire logic [7:0] FAN_DUTY_IN_1,
	input wire logic [7:0] FAN_DUTY_IN_2,
	input wire logic [7:0] FAN_DUTY_IN_3,
	output logic [7:0] FAN_DUTY_OUT_1,
	output logic [7:0] FAN_DUTY_OUT_2,
	output logic [7:0] FAN_DUTY_OUT_3,
	input wire logic [7:0] ZONE1_READING,
	input wire logic [7:0] ZONE2_READING,
	input wire logic [7:0] ZONE3_READING,
	input wire logic [2:0] ZONE_READING_UPD,
	input wire logic [5:0] AVG_DONE,
	output logic [5:0] READING_LOAD,
	input wire logic FAN_SPEED_IN_1,
	input wire logic FAN_SPEED_IN_2,
	input wire logic FAN_SPEED_IN_3,
	input wire logic FAN_SPEED_IN_4,
	input wire logic FAN_DRIVE_OUT_2,
	input wire logic FAN_DRIVE_OUT_3,
	output logic PARITY_TREE_OUT,
	output logic PARITY_TEST_MODE,
	input wire logic IRQ_EVENT,
	output logic IRQ_N_O,
	output logic IRQ_N_OE_N,
	output logic POWER_SAVE_SELECT,
	output logic MONITOR_CYCLE_SELECT,
	output logic [7:0] AVG_REMOTE_COUNT,
	output logic [7:0] AVG_LOCAL_COUNT,
	output logic OVERRIDE_ACTIVE
);
	//------------------------------------------------------------
	// register file
	//------------------------------------------------------------
	logic [7:0] zone_limit_r [NUM_ZONES];
	logic [7:0] parity_tree_test_ctrl_r;
	logic [7:0] monitor_special_ctrl_r;
	logic [7:0] rdata_r;
	logic rvalid_r;

	wire logic wr_ok = REG_REQ.wr & ~LOCK;
	wire logic hit_z1 = REG_REQ.addr == ADDR_ZONE1_ABS;
	wire logic hit_z2 = REG_REQ.addr == ADDR_ZONE2_ABS;
	wire logic hit_z3 = REG_REQ.addr == ADDR_ZONE3_ABS;
	wire logic hit_test = REG_REQ.addr == ADDR_PARITY_TEST;
	wire logic hit_spec = REG_REQ.addr == ADDR_SPECIAL;
	wire logic [NUM_ZONES-1:0] hit_zone = {hit_z3, hit_z2, hit_z1};

	genvar z;
	generate
		for (z = 0; z < NUM_ZONES; z++)
		begin : g_limit
			always_ff @(posedge REF_CLK)
			begin
				if (SYS_RST)
					zone_limit_r[z] <= ABS_LIMIT_RST;
				else if (wr_ok && hit_zone[z])
					zone_limit_r[z] <= REG_REQ.wdata;
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			parity_tree_test_ctrl_r <= PARITY_TEST_RST;
			monitor_special_ctrl_r <= SPECIAL_RST;
		end
		else
		begin
			if (wr_ok && hit_test)
				parity_tree_test_ctrl_r <= {7'h00, REG_REQ.wdata[0]};
			if (wr_ok && hit_spec)
				monitor_special_ctrl_r <= REG_REQ.wdata;
		end
	end

	//------------------------------------------------------------
	// read back
	//------------------------------------------------------------
	wire logic [7:0] rd_mux = hit_z1 ? zone_limit_r[0] :
		hit_z2 ? zone_limit_r[1] :
		hit_z3 ? zone_limit_r[2] :
		hit_test ? parity_tree_test_ctrl_r :
		hit_spec ? monitor_special_ctrl_r : 8'h00;

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= REG_REQ.rd;
			if (REG_REQ.rd)
				rdata_r <= rd_mux;
		end
	end
	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;

	//------------------------------------------------------------
	// special function fields
	//------------------------------------------------------------
	wire logic global_irq_enable = monitor_special_ctrl_r[BIT_IRQ_EN];
	wire logic [2:0] avg_sel = monitor_special_ctrl_r[BIT_AVG_LO +: 3];
	avg_count_t avg_counts;

	avg_decode u_avg
	(
		.sel(avg_sel),
		.counts(avg_counts)
	);

	assign POWER_SAVE_SELECT = monitor_special_ctrl_r[BIT_POWER_SAVE];
	assign MONITOR_CYCLE_SELECT = monitor_special_ctrl_r[BIT_MON_CYCLE];
	assign AVG_REMOTE_COUNT = avg_counts.remote_count;
	assign AVG_LOCAL_COUNT = avg_counts.local_count;
	assign READING_LOAD = AVG_DONE;

	// pin drives low only while enabled and an event is pending
	assign IRQ_N_O = 1'b0;
	assign IRQ_N_OE_N = ~(global_irq_enable & IRQ_EVENT);

	//------------------------------------------------------------
	// absolute limit override
	//------------------------------------------------------------
	wire logic [7:0] zone_reading [NUM_ZONES];
	logic [NUM_ZONES-1:0] zone_over;
	assign zone_reading[0] = ZONE1_READING;
	assign zone_reading[1] = ZONE2_READING;
	assign zone_reading[2] = ZONE3_READING;

	generate
		for (z = 0; z < NUM_ZONES; z++)
		begin : g_over
			abs_override u_over
			(
				.clk(REF_CLK),
				.rst(SYS_RST),
				.reading(zone_reading[z]),
				.reading_upd(ZONE_READING_UPD[z]),
				.limit(zone_limit_r[z]),
				.over(zone_over[z])
			);
		end
	endgenerate

	// any zone counts, mapped to a fan or not
	wire logic force_full = (|AUTO_MODE) & (|zone_over);
	assign OVERRIDE_ACTIVE = force_full;

	wire logic [7:0] duty_in [NUM_FANS];
	logic [7:0] duty_r [NUM_FANS];
	assign duty_in[0] = FAN_DUTY_IN_1;
	assign duty_in[1] = FAN_DUTY_IN_2;
	assign duty_in[2] = FAN_DUTY_IN_3;

	genvar f;
	generate
		for (f = 0; f < NUM_FANS; f++)
		begin : g_fan
			// manual fans are forced too; disabled fans keep their own duty
			wire logic [7:0] duty_nxt = (force_full && !FAN_DISABLE[f]) ? FULL_DUTY :
				duty_in[f];
			always_ff @(posedge REF_CLK)
			begin
				if (SYS_RST)
					duty_r[f] <= 8'h00;
				else
					duty_r[f] <= duty_nxt;
			end
		end
	endgenerate
	assign FAN_DUTY_OUT_1 = duty_r[0];
	assign FAN_DUTY_OUT_2 = duty_r[1];
	assign FAN_DUTY_OUT_3 = duty_r[2];

	//------------------------------------------------------------
	// parity tree test
	//------------------------------------------------------------
	logic [5:0] pin_s1_r;
	logic [5:0] pin_s2_r;
	logic [5:0] pin_s3_r;
	logic [5:0] pin_stable_r;
	logic tree_r;
	// bus pins are deliberately not part of this vector
	wire logic [5:0] tree_pins = {FAN_DRIVE_OUT_3, FAN_DRIVE_OUT_2, FAN_SPEED_IN_4,
		FAN_SPEED_IN_3, FAN_SPEED_IN_2, FAN_SPEED_IN_1};
	wire logic [5:0] agree = ~(pin_s2_r ^ pin_s3_r);
	wire logic [5:0] stable_nxt = (agree & pin_s2_r) | (~agree & pin_stable_r);
	wire logic test_en = parity_tree_test_ctrl_r[0];

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			pin_s1_r <= 6'h00;
			pin_s2_r <= 6'h00;
			pin_s3_r <= 6'h00;
			pin_stable_r <= 6'h00;
			tree_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= tree_pins;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_stable_r <= stable_nxt;
			tree_r <= test_en & (^stable_nxt);
		end
	end
	assign PARITY_TREE_OUT = tree_r;
	assign PARITY_TEST_MODE = test_en;
endmodule

// ---- hwmon_regs_properties.sv ----
`timescale 1ns/1ns
module hwmon_regs_properties
	import hwmon_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input hwmon_pkg::reg_req_t REG_REQ,
	input wire logic REG_RVALID,
	input wire logic LOCK,
	input wire logic [2:0] FAN_DISABLE,
	input wire logic [7:0] FAN_DUTY_IN_1,
	input wire logic [7:0] FAN_DUTY_OUT_1,
	input wire logic IRQ_EVENT,
	input wire logic IRQ_N_OE_N,
	input wire logic POWER_SAVE_SELECT,
	input wire logic MONITOR_CYCLE_SELECT,
	input wire logic PARITY_TEST_MODE,
	input wire logic [7:0] AVG_REMOTE_COUNT,
	input wire logic [7:0] AVG_LOCAL_COUNT,
	input wire logic OVERRIDE_ACTIVE
);
	// ------------------------------
	// register and override checks
	// ------------------------------
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_wr_special;
		!LOCK && REG_REQ.wr && REG_REQ.addr == ADDR_SPECIAL;
	endsequence
	a_rvalid_after_read: assert property (REG_REQ.rd |=> REG_RVALID)
		else $error("read not answered");
	a_locked_write: assert property (LOCK && REG_REQ.wr |=> $stable(POWER_SAVE_SELECT))
		else $error("locked write changed a register");
	a_mode_bits: assert property (s_wr_special |=>
		{MONITOR_CYCLE_SELECT, POWER_SAVE_SELECT} == $past(REG_REQ.wdata[1:0]))
		else $error("mode bits not written");
	a_test_enable: assert property (!LOCK && REG_REQ.wr && REG_REQ.addr == ADDR_PARITY_TEST
		|=> PARITY_TEST_MODE == $past(REG_REQ.wdata[0]))
		else $error("test enable not written");
	a_avg_priority: assert property (s_wr_special ##0 REG_REQ.wdata[7] |=>
		AVG_REMOTE_COUNT == AVG_32 && AVG_LOCAL_COUNT == AVG_32)
		else $error("top averaging bit not dominant");
	a_irq_gate: assert property (!IRQ_N_OE_N |-> IRQ_EVENT)
		else $error("interrupt pin driven without event");
	a_forced_duty: assert property (OVERRIDE_ACTIVE && !FAN_DISABLE[0] |=> FAN_DUTY_OUT_1 == FULL_DUTY)
		else $error("fan not forced to full");
	a_duty_follows: assert property (!OVERRIDE_ACTIVE || FAN_DISABLE[0] |=>
		FAN_DUTY_OUT_1 == $past(FAN_DUTY_IN_1))
		else $error("fan duty not passed through");
endmodule

// ---- zone_sensor_model.sv ----
`timescale 1ns/1ns
module zone_sensor_model
(
	input wire logic clk,
	output logic [7:0] reading_1,
	output logic [7:0] reading_2,
	output logic [7:0] reading_3,
	output logic [2:0] upd
);
	// ------------------------------
	// reading valid only with its update pulse
	// ------------------------------
	logic [7:0] val [3] = '{8'h00, 8'h00, 8'h00};
	assign reading_1 = val[0];
	assign reading_2 = val[1];
	assign reading_3 = val[2];
	initial upd = 3'h0;
	task automatic send(input int z, input logic [7:0] v);
		@(negedge clk);
		val[z] = v;
		upd[z] = 1'b1;
		@(negedge clk);
		upd[z] = 1'b0;
		// stale value is not held after the pulse
		val[z] = ~v;
	endtask
endmodule

// ---- hwmon_regs_tb_top.sv ----
`timescale 1ns/1ns
module hwmon_regs_tb_top
	import hwmon_pkg::*;
;
	logic REF_CLK = 1'b0, SYS_RST = 1'b1, LOCK = 1'b0, IRQ_EVENT = 1'b0;
	reg_req_t REG_REQ = '0;
	logic [2:0] AUTO_MODE = 3'h0, FAN_DISABLE = 3'h0, ZONE_READING_UPD;
	logic [5:0] AVG_DONE = 6'h00, READING_LOAD, pins = 6'h00;
	logic [7:0] FAN_DUTY_IN_1 = 8'h11, FAN_DUTY_IN_2 = 8'h22, FAN_DUTY_IN_3 = 8'h33;
	logic [7:0] REG_RDATA, FAN_DUTY_OUT_1, FAN_DUTY_OUT_2, FAN_DUTY_OUT_3, AVG_REMOTE_COUNT;
	logic [7:0] AVG_LOCAL_COUNT, ZONE1_READING, ZONE2_READING, ZONE3_READING;
	logic REG_RVALID, PARITY_TREE_OUT, PARITY_TEST_MODE, IRQ_N_O, IRQ_N_OE_N, OVERRIDE_ACTIVE;
	logic POWER_SAVE_SELECT, MONITOR_CYCLE_SELECT;
	logic [15:0] avg_exp;
	logic [7:0] addrs [6] = '{ADDR_ZONE1_ABS, ADDR_ZONE2_ABS, ADDR_ZONE3_ABS, ADDR_PARITY_TEST,
		ADDR_SPECIAL, 8'h6d};
	logic [7:0] rst_vals [6] = '{8'h64, 8'h64, 8'h64, 8'h00, 8'h40, 8'h00};
	int error_cnt = 0, check_count = 0;
	always #5 REF_CLK = ~REF_CLK;
	hwmon_regs u_hwmon_regs (.*, .FAN_SPEED_IN_1(pins[0]), .FAN_SPEED_IN_2(pins[1]),
		.FAN_SPEED_IN_3(pins[2]), .FAN_SPEED_IN_4(pins[3]), .FAN_DRIVE_OUT_2(pins[4]),
		.FAN_DRIVE_OUT_3(pins[5]));
	zone_sensor_model u_zone_sensor_model (.clk(REF_CLK), .reading_1(ZONE1_READING),
		.reading_2(ZONE2_READING), .reading_3(ZONE3_READING), .upd(ZONE_READING_UPD));
	// ------------------------------
	// bus tasks and comparison
	// ------------------------------
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge REF_CLK);
		REG_REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge REF_CLK);
		REG_REQ.wr = 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(negedge REF_CLK);
		REG_REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge REF_CLK);
		REG_REQ.rd = 1'b0;
		check("read valid", 8'h01, {7'h0, REG_RVALID});
		check(name, exp, REG_RDATA);
	endtask
	task automatic zone(input int z, input logic [7:0] v, input logic hot);
		u_zone_sensor_model.send(z, v);
		repeat (2) @(negedge REF_CLK);
		check("duty 1", hot ? FULL_DUTY : 8'h11, FAN_DUTY_OUT_1);
		check("duty 2", hot ? FULL_DUTY : 8'h22, FAN_DUTY_OUT_2);
		check("duty 3", 8'h33, FAN_DUTY_OUT_3);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ------------------------------
	// test sequence
	// ------------------------------
	initial
	begin
		repeat (4) @(negedge REF_CLK);
		SYS_RST = 1'b0;
		for (int i = 0; i < 6; i++)
			rd_chk("reset value", addrs[i], rst_vals[i]);
		for (int c = 0; c < 8; c++)
		begin
			wr(ADDR_SPECIAL, {c[2:0], 3'h0, c[1:0]});
			avg_exp = c[2] ? {AVG_32, AVG_32} : c[1] ? {AVG_16, AVG_16} :
				c[0] ? {AVG_16, AVG_1} : {AVG_128, AVG_8};
			check("remote count", avg_exp[15:8], AVG_REMOTE_COUNT);
			check("local count", avg_exp[7:0], AVG_LOCAL_COUNT);
			check("mode bits", {6'h0, c[1:0]}, {6'h0, MONITOR_CYCLE_SELECT, POWER_SAVE_SELECT});
		end
		IRQ_EVENT = 1'b1;
		wr(ADDR_SPECIAL, 8'h40);
		@(negedge REF_CLK);
		check("irq disabled", 8'h01, {7'h0, IRQ_N_OE_N});
		wr(ADDR_SPECIAL, 8'h44);
		@(negedge REF_CLK);
		check("irq enabled", 8'h00, {7'h0, IRQ_N_OE_N});
		check("pin level", 8'h00, {7'h0, IRQ_N_O});
		wr(ADDR_PARITY_TEST, 8'hff);
		check("test mode on", 8'h01, {7'h0, PARITY_TEST_MODE});
		rd_chk("test register", ADDR_PARITY_TEST, 8'h01);
		for (int p = 0; p < 4; p++)
		begin
			if (p == 3)
			begin
				wr(ADDR_PARITY_TEST, 8'h00);
				check("test mode off", 8'h00, {7'h0, PARITY_TEST_MODE});
			end
			pins = 6'h15 << p;
			repeat (5) @(negedge REF_CLK);
			check("parity tree", {7'h0, ^pins && p < 3}, {7'h0, PARITY_TREE_OUT});
		end
		AVG_DONE = 6'h2a;
		AUTO_MODE = 3'h1;
		FAN_DISABLE = 3'h4;
		zone(2, 8'h65, 1'b1);
		zone(2, 8'h64, 1'b0);
		wr(ADDR_ZONE2_ABS, 8'hce);
		zone(1, 8'h81, 1'b0);
		zone(1, 8'h00, 1'b1);
		wr(ADDR_ZONE2_ABS, ABS_LIMIT_OFF);
		zone(1, 8'h7f, 1'b0);
		rd_chk("zone2 limit", ADDR_ZONE2_ABS, 8'h80);
		wr(ADDR_ZONE3_ABS, ABS_LIMIT_MAX);
		zone(2, 8'h7f, 1'b0);
		AUTO_MODE = 3'h0;
		zone(0, 8'h7f, 1'b0);
		check("reading load", 8'h2a, {2'h0, READING_LOAD});
		LOCK = 1'b1;
		wr(ADDR_ZONE1_ABS, 8'h10);
		wr(ADDR_SPECIAL, 8'h00);
		rd_chk("locked limit", ADDR_ZONE1_ABS, 8'h64);
		rd_chk("locked special", ADDR_SPECIAL, 8'h44);
		print_verdict();
	end
	initial
	begin
		#1000000;
		error_cnt++;
		print_verdict();
	end
endmodule
bind hwmon_regs hwmon_regs_properties u_hwmon_regs_properties (.*);
